// ==== rtl/rc_tune_pkg.sv ====
// Constants for the fast RC oscillator self-tune control block
package rc_tune_pkg;
    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [3:0] TUNE_CTRL_OFS  = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h4;
    localparam logic [3:0] IRQ_MASK_OFS   = 4'h8;
    // -------------------------------------------------------------
    // Tune control field positions
    // -------------------------------------------------------------
    localparam int ENABLE_BIT   = 15;
    localparam int RESERVED_BIT = 14;
    localparam int STOP_IDLE_BIT = 13;
    localparam int REF_SEL_BIT  = 12;
    localparam int LOCK_BIT     = 11;
    localparam int POLARITY_BIT = 10;
    localparam int OOR_BIT      = 9;
    localparam int TRIM_W       = 6;
    // -------------------------------------------------------------
    // Interrupt status bits and reset values
    // -------------------------------------------------------------
    localparam int IRQ_LOCK_BIT = 0;
    localparam int IRQ_OOR_BIT  = 1;
    localparam int IRQ_W        = 2;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;
    // -------------------------------------------------------------
    // Reference rates and lock window (0.2 % = 2 per mille)
    // -------------------------------------------------------------
    localparam int SEC_REF_HZ      = 32768;
    localparam int USB_REF_HZ      = 1000;
    localparam int RC_NOMINAL_HZ   = 8000000;
    localparam int LOCK_TOL_PERMIL = 2;
endpackage

// ==== rtl/rc_self_tune.sv ====
// Self-tune control, status and interrupt logic for the fast RC oscillator
//
// Functional notes
// R01: Enable set: hardware owns the trim field; clear: software may write trim.
// R02: Bit 14 of tune control reads zero; writes to it do nothing.
// R03: Stop-in-idle set halts tuning while core idles; clear keeps tuning.
// R04: Reference select one tunes to USB timing, zero to 32.768 kHz oscillator.
// R05: Lock flag set within 0.2 percent of reference, cleared otherwise.
// R06: Polarity one raises lock interrupt on lock zero, else on lock one.
// R07: Out-of-range flag set when trim cannot correct; no adjustment then.
// R08: Lock and out-of-range flags read-only, updated each evaluation.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
module rc_self_tune #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator and reference events
    input  wire logic        osc_tick_i,
    input  wire logic        ref_usb_tick_i,
    input  wire logic        ref_32k_tick_i,
    input  wire logic        core_idle_i,
    // Results
    output logic [rc_tune_pkg::TRIM_W-1:0] rc_trim_value_o,
    output logic             irq_o
);
    // Expected oscillator ticks per reference period and lock window
    localparam logic [CNT_W-1:0] TARGET_32K = CNT_W'(
        rc_tune_pkg::RC_NOMINAL_HZ / rc_tune_pkg::SEC_REF_HZ);
    localparam logic [CNT_W-1:0] TARGET_USB = CNT_W'(
        rc_tune_pkg::RC_NOMINAL_HZ / rc_tune_pkg::USB_REF_HZ);
    localparam logic [CNT_W-1:0] TOL_32K = CNT_W'(
        rc_tune_pkg::RC_NOMINAL_HZ / rc_tune_pkg::SEC_REF_HZ
        * rc_tune_pkg::LOCK_TOL_PERMIL / 1000);
    localparam logic [CNT_W-1:0] TOL_USB = CNT_W'(
        rc_tune_pkg::RC_NOMINAL_HZ / rc_tune_pkg::USB_REF_HZ
        * rc_tune_pkg::LOCK_TOL_PERMIL / 1000);
    localparam logic [rc_tune_pkg::TRIM_W-1:0] TRIM_MAX = '1;
    localparam logic [rc_tune_pkg::TRIM_W-1:0] TRIM_ONE = 6'h01;
    localparam logic [CNT_W-1:0]               CNT_ONE  = CNT_W'(1);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    logic                 self_tune_enable;
    logic                 tune_stop_in_idle;
    logic                 tune_reference_select;
    logic                 tune_lock_flag;
    logic                 lock_irq_polarity;
    logic                 tune_out_of_range_flag;
    logic [CNT_W-1:0]     osc_count;
    logic                 primed;
    logic [rc_tune_pkg::IRQ_W-1:0] irq_status;
    logic [rc_tune_pkg::IRQ_W-1:0] irq_mask;
    logic                 lock_cond_d;
    logic                 oor_d;

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    logic        bus_req;
    logic        bus_wr;
    logic        wr_ctrl;
    logic        wr_status;
    logic        wr_mask;
    logic [31:0] next_dat;
    logic [31:0] ctrl_word;

    // Request from cyc and stb, write also qualified by the ack
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign bus_wr    = bus_req & wb_we_i & wb_ack_o;
    assign wr_ctrl   = bus_wr && wb_adr_i == rc_tune_pkg::TUNE_CTRL_OFS;
    assign wr_status = bus_wr && wb_adr_i == rc_tune_pkg::IRQ_STATUS_OFS;
    assign wr_mask   = bus_wr && wb_adr_i == rc_tune_pkg::IRQ_MASK_OFS;

    // Tune control image, bit 14 tied low
    always_comb begin
        ctrl_word = '0;
        ctrl_word[rc_tune_pkg::ENABLE_BIT]    = self_tune_enable;
        // R02: unused bit reads zero
        ctrl_word[rc_tune_pkg::RESERVED_BIT]  = 1'b0;
        ctrl_word[rc_tune_pkg::STOP_IDLE_BIT] = tune_stop_in_idle;
        ctrl_word[rc_tune_pkg::REF_SEL_BIT]   = tune_reference_select;
        ctrl_word[rc_tune_pkg::LOCK_BIT]      = tune_lock_flag;
        ctrl_word[rc_tune_pkg::POLARITY_BIT]  = lock_irq_polarity;
        ctrl_word[rc_tune_pkg::OOR_BIT]       = tune_out_of_range_flag;
        ctrl_word[rc_tune_pkg::TRIM_W-1:0]    = rc_trim_value_o;
    end

    // Read mux, unmapped reads return zero
    always_comb begin
        next_dat = '0;
        case (wb_adr_i)
            rc_tune_pkg::TUNE_CTRL_OFS:  next_dat = ctrl_word;
            rc_tune_pkg::IRQ_STATUS_OFS: next_dat[1:0] = irq_status;
            rc_tune_pkg::IRQ_MASK_OFS:   next_dat[1:0] = irq_mask;
            default:                     next_dat = '0;
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= next_dat;
        end
    end

    // -------------------------------------------------------------
    // Software control bits
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            self_tune_enable      <= 1'b0;
            tune_stop_in_idle     <= 1'b0;
            tune_reference_select <= 1'b0;
            lock_irq_polarity     <= 1'b0;
            irq_mask              <= rc_tune_pkg::IRQ_RESET;
        end else begin
            if (wr_ctrl && wb_sel_i[1]) begin
                self_tune_enable <= wb_dat_i[rc_tune_pkg::ENABLE_BIT];
                tune_stop_in_idle <= wb_dat_i[rc_tune_pkg::STOP_IDLE_BIT];
                tune_reference_select <= wb_dat_i[rc_tune_pkg::REF_SEL_BIT];
                lock_irq_polarity <= wb_dat_i[rc_tune_pkg::POLARITY_BIT];
            end
            if (wr_mask && wb_sel_i[0])
                irq_mask <= wb_dat_i[rc_tune_pkg::IRQ_W-1:0];
        end
    end

    // -------------------------------------------------------------
    // Frequency measurement
    // -------------------------------------------------------------
    logic             active;
    logic             ref_tick;
    logic             eval;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] tol;
    logic [CNT_W:0]   hi_lim;
    logic [CNT_W:0]   cnt_tol;
    logic             too_fast;
    logic             too_slow;
    logic             in_lock;
    logic             oor_now;

    // R03: idle halts tuning only when stop-in-idle is set
    assign active   = self_tune_enable & ~(core_idle_i & tune_stop_in_idle);
    // R04: reference chosen by the select bit
    assign ref_tick = tune_reference_select ? ref_usb_tick_i
                                            : ref_32k_tick_i;
    assign target   = tune_reference_select ? TARGET_USB : TARGET_32K;
    assign tol      = tune_reference_select ? TOL_USB : TOL_32K;
    assign eval     = active & ref_tick & primed;

    // Window compare against the expected tick count
    assign hi_lim   = {1'b0, target} + {1'b0, tol};
    assign cnt_tol  = {1'b0, osc_count} + {1'b0, tol};
    assign too_fast = {1'b0, osc_count} > hi_lim;
    assign too_slow = cnt_tol < {1'b0, target};
    assign in_lock  = ~too_fast & ~too_slow;
    assign oor_now  = (too_fast && rc_trim_value_o == '0) ||
                      (too_slow && rc_trim_value_o == TRIM_MAX);

    // Count oscillator ticks over one reference period
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_count <= '0;
            primed    <= 1'b0;
        end else if (!active) begin
            osc_count <= '0;
            primed    <= 1'b0;
        end else if (ref_tick) begin
            osc_count <= {{(CNT_W-1){1'b0}}, osc_tick_i};
            primed    <= 1'b1;
        end else if (osc_tick_i && osc_count != '1) begin
            osc_count <= osc_count + CNT_ONE;
        end
    end

    // -------------------------------------------------------------
    // Status flags and trim
    // -------------------------------------------------------------
    // R05: lock follows each evaluation, dropped when tuning stops
    // R08: flags written by hardware only
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tune_lock_flag         <= 1'b0;
            tune_out_of_range_flag <= 1'b0;
        end else if (!active) begin
            tune_lock_flag         <= 1'b0;
        end else if (eval) begin
            tune_lock_flag         <= in_lock;
            // R07: flag when trim range is exhausted
            tune_out_of_range_flag <= oor_now;
        end
    end

    // R01: hardware owns trim while enabled
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rc_trim_value_o <= rc_tune_pkg::TRIM_RESET;
        end else if (self_tune_enable) begin
            // R07: no step while out of range
            if (eval && !oor_now && too_fast)
                rc_trim_value_o <= rc_trim_value_o - TRIM_ONE;
            else if (eval && !oor_now && too_slow)
                rc_trim_value_o <= rc_trim_value_o + TRIM_ONE;
        end else if (wr_ctrl && wb_sel_i[0]) begin
            rc_trim_value_o <= wb_dat_i[rc_tune_pkg::TRIM_W-1:0];
        end
    end

    // -------------------------------------------------------------
    // Interrupts
    // -------------------------------------------------------------
    logic                          lock_cond;
    logic [rc_tune_pkg::IRQ_W-1:0] irq_event;

    // R06: lock interrupt level chosen by polarity
    assign lock_cond = tune_lock_flag ^ lock_irq_polarity;
    assign irq_event[rc_tune_pkg::IRQ_LOCK_BIT] = lock_cond & ~lock_cond_d;
    assign irq_event[rc_tune_pkg::IRQ_OOR_BIT]  =
        tune_out_of_range_flag & ~oor_d;

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_cond_d <= 1'b0;
            oor_d       <= 1'b0;
            irq_status  <= rc_tune_pkg::IRQ_RESET;
            irq_o       <= 1'b0;
        end else begin
            lock_cond_d <= lock_cond;
            oor_d       <= tune_out_of_range_flag;
            irq_status  <= (irq_status & ~((wr_status && wb_sel_i[0]) ?
                           wb_dat_i[rc_tune_pkg::IRQ_W-1:0] : 2'h0))
                           | irq_event;
            irq_o       <= |(irq_status & irq_mask);
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_sw_trim_write;
        !self_tune_enable && wr_ctrl && wb_sel_i[0];
    endsequence

    a_sw_trim_own: assert property (s_sw_trim_write |=> // R01
        rc_trim_value_o == $past(wb_dat_i[5:0]))
        else $error("software trim write lost");
    a_reserved_zero: assert property (wb_ack_o && // R02
        $past(wb_adr_i) == rc_tune_pkg::TUNE_CTRL_OFS |-> !wb_dat_o[14])
        else $error("reserved bit reads one");
    a_idle_stops_tune: assert property (self_tune_enable && // R03
        core_idle_i && tune_stop_in_idle |=>
        !tune_lock_flag && $stable(rc_trim_value_o))
        else $error("tuning ran in idle");
    a_ref_select: assert property (active && !tune_reference_select && // R04
        ref_usb_tick_i && !ref_32k_tick_i |-> !eval && !ref_tick)
        else $error("wrong reference used");
    a_lock_update: assert property (eval |=> // R05
        tune_lock_flag == $past(in_lock))
        else $error("lock flag not updated");
    a_lock_irq_pol: assert property ($rose(lock_cond) |=> // R06
        irq_status[rc_tune_pkg::IRQ_LOCK_BIT])
        else $error("lock interrupt missed");
    a_oor_freeze: assert property (eval && oor_now |=> // R07
        tune_out_of_range_flag && $stable(rc_trim_value_o))
        else $error("trim moved out of range");
    a_flags_ro: assert property (wr_ctrl && !eval && active |=> // R08
        $stable(tune_lock_flag) && $stable(tune_out_of_range_flag))
        else $error("software changed status flag");
endmodule

// ==== test/fast_rc_self_tune_status_test.sv ====
// Self-checking bench for the fast RC self-tune control block
module fast_rc_self_tune_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals and bench state
    // ----------------------------------------------------------------
    logic        clk_sys_i       = 1'b0;
    logic        rstn_i          = 1'b0;
    logic        wb_cyc_i        = 1'b0;
    logic        wb_stb_i        = 1'b0;
    logic        wb_we_i         = 1'b0;
    logic [3:0]  wb_adr_i        = 4'h0;
    logic [3:0]  wb_sel_i        = 4'h0;
    logic [31:0] wb_dat_i        = 32'h0;
    logic        osc_tick_i      = 1'b0;
    logic        ref_usb_tick_i  = 1'b0;
    logic        ref_32k_tick_i  = 1'b0;
    logic        core_idle_i     = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [5:0]  rc_trim_value_o;
    logic        irq_o;
    int          error_cnt       = 0;
    int          checked         = 0;
    int          cycles          = 0;
    int          seed            = 32'h9e97;
    logic [31:0] rd;
    logic [5:0]  e_trim          = 6'h20;
    logic        e_lock          = 1'b0;
    logic        e_oor           = 1'b0;
    logic        en              = 1'b0;
    logic        stop            = 1'b0;
    logic        rsel            = 1'b0;
    logic        pol             = 1'b0;

    rc_self_tune rc_self_tune_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .osc_tick_i(osc_tick_i),
        .ref_usb_tick_i(ref_usb_tick_i), .ref_32k_tick_i(ref_32k_tick_i),
        .core_idle_i(core_idle_i), .rc_trim_value_o(rc_trim_value_o),
        .irq_o(irq_o)
    );

    // Clock and hang guard
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [3:0] adr,
                       input logic [3:0] sel, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        chk(wb_ack_o, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] adr, input logic [31:0] exp,
                        input logic [31:0] msk);
        bus(1'b0, adr, 4'hf, 32'h0);
        chk(rd & msk, exp);
    endtask

    // Config bits only, lane 1, trim left alone
    task automatic cfg();
        bus(1'b1, 4'h0, 4'h2, {16'h0, en, 1'b0, stop, rsel, 1'b0, pol, 10'h0});
    endtask

    task automatic st_chk();
        rchk(4'h0, {16'h0, en, 1'b0, stop, rsel, e_lock, pol, e_oor, 3'h0,
                    e_trim}, 32'hfe3f);
        chk(rc_trim_value_o, e_trim);
    endtask

    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(irq_o, exp);
    endtask

    // Oscillator ticks, a stray unselected ref, then the selected ref
    task automatic window(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            osc_tick_i     <= 1'b1;
            ref_usb_tick_i <= !rsel && i == 2;
            ref_32k_tick_i <= rsel && i == 2;
        end
        @(posedge clk_sys_i);
        osc_tick_i     <= 1'b0;
        ref_usb_tick_i <= 1'b0;
        ref_32k_tick_i <= 1'b0;
        @(posedge clk_sys_i);
        ref_usb_tick_i <= rsel;
        ref_32k_tick_i <= !rsel;
        @(posedge clk_sys_i);
        ref_usb_tick_i <= 1'b0;
        ref_32k_tick_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask

    // Expected flags and trim after one evaluation
    function automatic void step(input int n);
        int ex;
        int tol;
        ex  = rc_tune_pkg::RC_NOMINAL_HZ /
              (rsel ? rc_tune_pkg::USB_REF_HZ : rc_tune_pkg::SEC_REF_HZ);
        tol = ex * rc_tune_pkg::LOCK_TOL_PERMIL / 1000;
        e_lock = n >= ex - tol && n <= ex + tol;
        e_oor  = (n > ex + tol && e_trim == 6'h00) ||
                 (n < ex - tol && e_trim == 6'h3f);
        if (!e_oor && n > ex + tol) e_trim = e_trim - 6'h01;
        else if (!e_oor && n < ex - tol) e_trim = e_trim + 6'h01;
    endfunction

    task automatic eval(input int n);
        window(n);
        step(n);
        st_chk();
    endtask

    // Fresh activation, first ref tick only primes
    task automatic restart();
        en = 1'b0;
        cfg();
        en = 1'b1;
        cfg();
        window(5);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (int a = 0; a < 16; a += 4) rchk(a[3:0], 32'h0, '1); // rst
        chk(rc_trim_value_o, 6'h00); // rst
        bus(1'b1, 4'h0, 4'h3, 32'h7e3f);
        rchk(4'h0, 32'h343f, '1); // bits
        chk(rc_trim_value_o, 6'h3f); // sw trim
        bus(1'b1, 4'hc, 4'hf, 32'hffff_ffff);
        rchk(4'hc, 32'h0, '1); // unmapped
        bus(1'b1, 4'h0, 4'h3, 32'h0020);
        bus(1'b1, 4'h4, 4'h1, 32'h3);
        rchk(4'h4, 32'h0, '1); // w1c
        bus(1'b1, 4'h8, 4'h1, 32'h3);
        rchk(4'h8, 32'h3, '1); // mask rw
        bus(1'b1, 4'h8, 4'h1, 32'h0);
        // lock on exact count, masked then unmasked
        restart();
        eval(244); // lock
        rchk(4'h4, 32'h1, 32'h1); // status
        chk_irq(1'b0); // masked
        bus(1'b1, 4'h8, 4'h1, 32'h1);
        chk_irq(1'b1); // irq
        bus(1'b1, 4'h4, 4'h1, 32'h1);
        chk_irq(1'b0); // cleared
        bus(1'b1, 4'h0, 4'h1, 32'h05);
        st_chk(); // hw owns
        // inverted polarity fires on loss of lock
        pol = 1'b1;
        cfg();
        eval(250); // unlock
        chk_irq(1'b1); // inverted
        bus(1'b1, 4'h4, 4'h1, 32'h1);
        pol = 1'b0;
        cfg();
        // random windows around the nominal count
        repeat (12) eval(235 + $unsigned($random(seed)) % 20);
        for (int k = 0; k < 2; k++) begin
            en = 1'b0;
            cfg();
            e_trim = k ? 6'h3f : 6'h00;
            bus(1'b1, 4'h0, 4'h1, {26'h0, e_trim});
            restart();
            eval(k ? 200 : 300); // oor
            eval(k ? 200 : 300); // frozen
            rchk(4'h4, 32'h2, 32'h2); // status
            bus(1'b1, 4'h4, 4'h1, 32'h2);
            // in-range window drops the flag so the next limit rises
            eval(244); // oor clears
        end
        // idle stop halts, clear keeps running
        stop = 1'b1;
        cfg();
        core_idle_i <= 1'b1;
        window(300);
        e_lock = 1'b0;
        st_chk(); // halted
        stop = 1'b0;
        cfg();
        window(5);
        eval(300); // runs
        core_idle_i <= 1'b0;
        // USB reference with stray secondary ticks
        rsel = 1'b1;
        restart();
        eval(8000); // usb lock
        eval(8100); // usb step
        stop_test();
    end
endmodule
